// ==== rtl/tpqt_pkg.sv ====
// shared constants and types for the tof pixel quality and timebase controller
package tpqt_pkg;
  // register map of the imager, reached through the register port
  localparam logic [7:0]  MOD_CLK_DIV_ADDR  = 8'h85;
  localparam logic [7:0]  MOD_CLK_DIV_RESET = 8'h01;
  // divider settings and matching integration multipliers
  localparam logic [7:0]  DIV_80M  = 8'h00;
  localparam logic [7:0]  DIV_40M  = 8'h01;
  localparam logic [7:0]  DIV_20M  = 8'h03;
  localparam logic [7:0]  DIV_10M  = 8'h07;
  localparam logic [7:0]  DIV_5M   = 8'h0F;
  localparam logic [4:0]  MULT_1   = 5'h01;
  localparam logic [4:0]  MULT_2   = 5'h02;
  localparam logic [4:0]  MULT_4   = 5'h04;
  localparam logic [4:0]  MULT_8   = 5'h08;
  localparam logic [4:0]  MULT_16  = 5'h10;
  // unambiguity distance in decimetres and resolution in hundredths of a mm per lsb
  localparam logic [11:0] UNAMB_DM_BASE = 12'h04B;  // 7.5 m
  localparam logic [11:0] RES_UM_BASE   = 12'h0FA;  // 0.25 cm = 2500 um / 10
  localparam logic [11:0] DIST_FULL_LSB = 12'hBB8;  // 3000 lsb operating range
  // amplitude class limits in lsb
  localparam logic [11:0] AMP_WEAK_LIM  = 12'h019;  // 25
  localparam logic [11:0] AMP_NOISY_LIM = 12'h064;  // 100
  localparam logic [11:0] AMP_OVER_LIM  = 12'h7D0;  // 2000
  localparam logic [11:0] AMP_AIM_LO    = 12'h0C8;  // 200
  localparam logic [11:0] AMP_AIM_HI    = 12'h5DC;  // 1500
  // ratio limits in db
  localparam logic [7:0]  AMR_GOOD_DB   = 8'h3C;    // 60
  localparam logic [7:0]  AMR_WEAK_DB   = 8'h46;    // 70
  // full scale fractions of 2047 lsb signed samples and amplitude
  localparam logic [11:0] FS_99_LSB     = 12'h7E9;  // 2025
  localparam logic [11:0] FS_1_LSB      = 12'h014;  // 20
  localparam logic [11:0] FS_5_LSB      = 12'h066;  // 102
  typedef enum logic [1:0] {ACT_KEEP, ACT_INC, ACT_DEC} tpqt_act_t;
  typedef enum logic [2:0] {CLS_NONE, CLS_SAT, CLS_BRIGHT, CLS_NO_OBJ, CLS_AMBIENT,
                            CLS_USABLE, CLS_MARGINAL} tpqt_cls_t;
  typedef enum logic [1:0] {AMP_WEAK, AMP_NOISY, AMP_GOOD, AMP_OVER} tpqt_amp_t;
endpackage

// ==== rtl/tpqt_isqrt.sv ====
// combinational integer square root of a 26-bit sum
`timescale 1ns/100ps
module tpqt_isqrt #(
  parameter int IN_W = 26
) (
  input  wire logic [IN_W-1:0]   radicand,
  output      logic [IN_W/2-1:0] root
);
  // restoring bit-by-bit root; a pipeline would cut depth but cost a cycle
  always_comb begin
    logic [IN_W/2-1:0] trial;
    root  = '0;
    trial = '0;
    for (int b = IN_W/2-1; b >= 0; b--) begin
      trial    = root;
      trial[b] = 1'b1;
      if ({{(IN_W/2){1'b0}}, trial} * {{(IN_W/2){1'b0}}, trial} <= {{(IN_W/2){1'b0}}, radicand}) begin
        root = trial;
      end
    end
  end
endmodule

// ==== rtl/tpqt_skid.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module tpqt_skid #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         rdy_r;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;
  wire  [1:0]   cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  // honest flags: ready drops only when both entries are full
  // ready sits in a flop so the top's ready port is registered, and low in reset
  assign in_ready  = rdy_r;
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
      rdy_r <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != 2'h2);
    end
  end
endmodule

// ==== rtl/tpqt_ctrl.sv ====
// host controller: divider programming and per-pixel quality classifier
`timescale 1ns/100ps
import tpqt_pkg::*;
// Overview of operation
// - unambiguity distance 7.5 m doubling to 120 m
// - 3000 lsb range, 0.25 cm resolution doubling
// - amplitude is half root of squared differences
// - amplitude classes weak, noisy, good, overexposed
// - weak/noisy increase, overexposed decrease, good keep
// - aim amplitude between 200 and 1500 lsb
// - modulated irradiance from sensitivity, time ratio, amplitude
// - ratio in db from ambient over modulated
// - ratio under 60 excellent, over 70 weak
// - overflow flag first: saturated, decrease time
// - samples beyond 99% decrease, all within 1% increase
// - amplitude and ratio checks pick final action
module tpqt_ctrl #(
  parameter int SAMP_W = 12,
  parameter int SENS_W = 8,
  parameter int TIME_W = 16
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      clk_en,
  // user side: divider order
  input  wire logic                      div_set_valid,
  input  wire logic [7:0]                div_set_code,
  output      logic                      div_set_ack,
  // imager register port
  output      logic                      reg_wr_en,
  output      logic [7:0]                reg_addr,
  output      logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr_done,
  // timebase results
  output      logic [4:0]                int_time_mult,
  output      logic [11:0]               unamb_dist_dm,
  output      logic [11:0]               dist_res_10um,
  output      logic                      div_code_bad,
  // pixel input from the imager
  input  wire logic                      pix_valid,
  output      logic                      pix_ready,
  input  wire logic signed [SAMP_W-1:0]  phase_sample0,
  input  wire logic signed [SAMP_W-1:0]  phase_sample1,
  input  wire logic signed [SAMP_W-1:0]  phase_sample2,
  input  wire logic signed [SAMP_W-1:0]  phase_sample3,
  input  wire logic                      pixel_overflow_flag,
  // ambient ratio inputs, modulation sensitivity and integration time terms
  input  wire logic                      amr_enable,
  input  wire logic [7:0]                ambient_to_modulated_ratio,
  input  wire logic [SENS_W-1:0]         mod_sensitivity,
  input  wire logic [TIME_W-1:0]         t_int_ref,
  input  wire logic [TIME_W-1:0]         t_int_used,
  // classified output stream
  output      logic                      cls_valid,
  input  wire logic                      cls_ready,
  output      logic [11:0]               modulated_amplitude,
  output      logic [31:0]               modulated_irradiance,
  output      tpqt_pkg::tpqt_cls_t       pix_class,
  output      tpqt_pkg::tpqt_amp_t       amp_class,
  output      tpqt_pkg::tpqt_act_t       int_action,
  output      logic                      dist_valid,
  output      logic                      amp_in_aim
);
  import tpqt_pkg::*;
  // widths the arithmetic below cannot serve are refused at elaboration
  if (SAMP_W != 12) begin : g_chk_samp
    $error("sample width must be 12");
  end
  if (SENS_W + TIME_W + 12 > 48) begin : g_chk_irr
    $error("irradiance product too wide");
  end
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  // the raw reset clears only these two flops; all other state uses the copy
  logic rst_s1_r;
  logic rst_n_r;
  // two flops keep release clean against the clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end
  // ---------------------------------------------------------------
  // divider programming and timebase
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {DS_IDLE, DS_WRITE, DS_ACK} tpqt_div_st_t;
  tpqt_div_st_t st_r;
  tpqt_div_st_t st_nxt;
  logic [7:0]   div_r;
  logic [7:0]   div_nxt;
  logic [4:0]   mult_w;
  logic [2:0]   shift_w;
  logic         code_ok_w;
  // decode of the legal divider codes
  always_comb begin
    mult_w    = MULT_2;
    shift_w   = 3'h1;
    code_ok_w = 1'b1;
    case (div_r)
      DIV_80M: begin mult_w = MULT_1;  shift_w = 3'h0; end
      DIV_40M: begin mult_w = MULT_2;  shift_w = 3'h1; end
      DIV_20M: begin mult_w = MULT_4;  shift_w = 3'h2; end
      DIV_10M: begin mult_w = MULT_8;  shift_w = 3'h3; end
      DIV_5M:  begin mult_w = MULT_16; shift_w = 3'h4; end
      default: code_ok_w = 1'b0;
    endcase
  end
  // a refused code leaves the stored setting and the imager untouched
  wire new_code_ok = (div_set_code == DIV_80M) || (div_set_code == DIV_40M) ||
                     (div_set_code == DIV_20M) || (div_set_code == DIV_10M) ||
                     (div_set_code == DIV_5M);
  // write sequencer; illegal codes are refused so the imager never sees them
  always_comb begin
    st_nxt  = st_r;
    div_nxt = div_r;
    case (st_r)
      DS_IDLE: begin
        if (div_set_valid && new_code_ok) begin
          div_nxt = div_set_code;
          st_nxt  = DS_WRITE;
        end
      end
      DS_WRITE: if (reg_wr_done) st_nxt = DS_ACK;
      DS_ACK:   st_nxt = DS_IDLE;
      default:  st_nxt = DS_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r          <= DS_IDLE;
      div_r         <= MOD_CLK_DIV_RESET;
      reg_wr_en     <= 1'b0;
      reg_addr      <= MOD_CLK_DIV_ADDR;
      reg_wdata     <= MOD_CLK_DIV_RESET;
      div_set_ack   <= 1'b0;
      div_code_bad  <= 1'b0;
      int_time_mult <= MULT_2;
      unamb_dist_dm <= UNAMB_DM_BASE << 1;
      dist_res_10um <= RES_UM_BASE << 1;
    end else if (clk_en) begin
      st_r          <= st_nxt;
      div_r         <= div_nxt;
      reg_wr_en     <= (st_nxt == DS_WRITE);
      reg_addr      <= MOD_CLK_DIV_ADDR;
      reg_wdata     <= div_nxt;
      div_set_ack   <= (st_nxt == DS_ACK);
      div_code_bad  <= (st_r == DS_IDLE) && div_set_valid && !new_code_ok;
      int_time_mult <= mult_w;
      unamb_dist_dm <= UNAMB_DM_BASE << shift_w;
      dist_res_10um <= RES_UM_BASE << shift_w;
    end
  end
  // ---------------------------------------------------------------
  // amplitude
  // ---------------------------------------------------------------
  wire signed [12:0] diff_a = 13'(phase_sample2) - 13'(phase_sample0);
  wire signed [12:0] diff_b = 13'(phase_sample3) - 13'(phase_sample1);
  wire        [25:0] sq_sum = 26'(diff_a * diff_a) + 26'(diff_b * diff_b);
  wire        [12:0] root_w;
  tpqt_isqrt #(.IN_W(26)) u_sqrt (
    .radicand (sq_sum),
    .root     (root_w)
  );
  // dropping the low root bit floors the same way as halving the exact root
  wire [11:0] amp_w = root_w[12:1];
  // ---------------------------------------------------------------
  // decision steps
  // ---------------------------------------------------------------
  // per-sample full scale checks, one per phase
  logic [SAMP_W-1:0] samp_w [4];
  logic [3:0]        over_w;
  logic [3:0]        small_w;
  assign samp_w[0] = phase_sample0;
  assign samp_w[1] = phase_sample1;
  assign samp_w[2] = phase_sample2;
  assign samp_w[3] = phase_sample3;
  // signed copies of the limits, else the compares turn unsigned and fail on negatives
  wire signed [12:0] fs99_s = 13'(FS_99_LSB);
  wire signed [12:0] fs1_s  = 13'(FS_1_LSB);
  for (genvar i = 0; i < 4; i++) begin : g_fs
    wire signed [12:0] s = 13'(signed'(samp_w[i]));
    assign over_w[i]  = (s > fs99_s) || (s < -fs99_s);
    assign small_w[i] = (s <= fs1_s) && (s >= -fs1_s);
  end
  // the bands do not overlap: each amplitude lands in exactly one class
  tpqt_amp_t amp_cls_w;
  assign amp_cls_w = (amp_w < AMP_WEAK_LIM)  ? AMP_WEAK  :
                     (amp_w < AMP_NOISY_LIM) ? AMP_NOISY :
                     (amp_w <= AMP_OVER_LIM) ? AMP_GOOD  : AMP_OVER;
  wire amr_weak = amr_enable && (ambient_to_modulated_ratio > AMR_WEAK_DB);
  wire amr_good = !amr_enable || (ambient_to_modulated_ratio < AMR_GOOD_DB);
  // the decision is combinational on the offered pixel; the buffer registers it
  tpqt_cls_t cls_w;
  tpqt_act_t act_w;
  // first matching step wins; overflow flag is checked before anything else
  always_comb begin
    cls_w = CLS_MARGINAL;
    act_w = ACT_KEEP;
    if (pixel_overflow_flag) begin
      cls_w = CLS_SAT;
      act_w = ACT_DEC;
    end else if (|over_w) begin
      cls_w = CLS_BRIGHT;
      act_w = ACT_DEC;
    end else if (&small_w) begin
      cls_w = CLS_NO_OBJ;
      act_w = ACT_INC;
    end else if (amp_w > FS_99_LSB) begin
      cls_w = CLS_BRIGHT;
      act_w = ACT_DEC;
    end else if (amp_w < FS_1_LSB) begin
      cls_w = CLS_NO_OBJ;
      act_w = ACT_INC;
    end else if (amr_weak) begin
      cls_w = CLS_AMBIENT;
      act_w = ACT_DEC;
    end else begin
      // amplitude class drives the action for remaining pixels
      cls_w = (amp_w >= FS_5_LSB && amr_good) ? CLS_USABLE : CLS_MARGINAL;
      case (amp_cls_w)
        AMP_WEAK, AMP_NOISY: act_w = ACT_INC;
        AMP_OVER:            act_w = ACT_DEC;
        default:             act_w = ACT_KEEP;
      endcase
    end
  end
  // irradiance is left unscaled: sensitivity x ref time x amp, divided by used time
  wire [47:0] irr_num = 48'(mod_sensitivity) * 48'(t_int_ref) * 48'(amp_w);
  wire [47:0] irr_w   = (t_int_used == '0) ? 48'h0 : irr_num / 48'(t_int_used);
  wire        aim_w   = (amp_w >= AMP_AIM_LO) && (amp_w <= AMP_AIM_HI);
  // ---------------------------------------------------------------
  // result buffer and output flops
  // ---------------------------------------------------------------
  // named fields of one buffered result
  typedef struct packed {
    logic [11:0] amp;
    logic [31:0] irr;
    tpqt_cls_t   cls;
    tpqt_amp_t   acls;
    tpqt_act_t   act;
    logic        dist_ok;
    logic        aim;
  } tpqt_pk_t;
  localparam int PK_W = 12 + 32 + 3 + 2 + 2 + 2;
  wire [PK_W-1:0] pk_in = {amp_w, irr_w[31:0], cls_w, amp_cls_w, act_w,
                           cls_w == CLS_USABLE, aim_w};
  // results leave in order; the output stage refills on the edge it empties
  tpqt_pk_t       pk_out;
  wire            buf_valid;
  wire            take = buf_valid && (!cls_valid || cls_ready);
  tpqt_skid #(.W(PK_W)) u_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n_r),
    .clk_en    (clk_en),
    .in_valid  (pix_valid),
    .in_ready  (pix_ready),
    .in_data   (pk_in),
    .out_valid (buf_valid),
    .out_ready (take),
    .out_data  (pk_out)
  );
  // output stage holds until the receiver takes it
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cls_valid            <= 1'b0;
      modulated_amplitude  <= 12'h000;
      modulated_irradiance <= 32'h0000_0000;
      pix_class            <= CLS_NONE;
      amp_class            <= AMP_WEAK;
      int_action           <= ACT_KEEP;
      dist_valid           <= 1'b0;
      amp_in_aim           <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        // all fields move together from the buffer head
        cls_valid            <= 1'b1;
        modulated_amplitude  <= pk_out.amp;
        modulated_irradiance <= pk_out.irr;
        pix_class            <= pk_out.cls;
        amp_class            <= pk_out.acls;
        int_action           <= pk_out.act;
        dist_valid           <= pk_out.dist_ok;
        amp_in_aim           <= pk_out.aim;
      end else if (cls_ready) begin
        cls_valid <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/tpqt_checker.sv ====
// concurrent checks on the ports of tpqt_ctrl
`timescale 1ns/100ps
module tpqt_checker (
  input wire logic                sys_clk,
  input wire logic                reset_n,
  input wire logic                div_set_valid,
  input wire logic [7:0]          div_set_code,
  input wire logic                div_set_ack,
  input wire logic                div_code_bad,
  input wire logic                reg_wr_en,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr_done,
  input wire logic [4:0]          int_time_mult,
  input wire logic [11:0]         unamb_dist_dm,
  input wire logic [11:0]         dist_res_10um,
  input wire logic                cls_valid,
  input wire logic                cls_ready,
  input wire logic [11:0]         modulated_amplitude,
  input wire tpqt_pkg::tpqt_cls_t pix_class,
  input wire tpqt_pkg::tpqt_amp_t amp_class,
  input wire tpqt_pkg::tpqt_act_t int_action,
  input wire logic                dist_valid,
  input wire logic                amp_in_aim
);
  import tpqt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // divider write and timebase
  // ----------------------------------------
  // zero marks a code the imager does not know
  function automatic logic [4:0] mult_of(logic [7:0] c);
    return (c == DIV_80M) ? MULT_1 : (c == DIV_40M) ? MULT_2 : (c == DIV_20M) ? MULT_4 :
           (c == DIV_10M) ? MULT_8 : (c == DIV_5M) ? MULT_16 : 5'h00;
  endfunction
  sequence wr_start;
    $rose(reg_wr_en);
  endsequence
  sequence wr_accept;
    reg_wr_en && reg_wr_done;
  endsequence
  AST_WR_ADDR: assert property (wr_start |-> reg_addr == MOD_CLK_DIV_ADDR && mult_of(reg_wdata) != 5'h00)
    else $error("divider write has wrong address or code");
  AST_WR_HOLD: assert property (reg_wr_en && !reg_wr_done |=> reg_wr_en && $stable(reg_wdata))
    else $error("divider write dropped before acceptance");
  AST_ACK: assert property (wr_accept |=> !reg_wr_en && div_set_ack ##1 !div_set_ack)
    else $error("divider acknowledge out of place");
  AST_MULT: assert property (wr_start |-> ##1 int_time_mult == mult_of($past(reg_wdata)))
    else $error("integration multiplier wrong");
  AST_SCALE: assert property (wr_start |-> ##1 unamb_dist_dm == UNAMB_DM_BASE * int_time_mult
    && dist_res_10um == RES_UM_BASE * int_time_mult) else $error("distance scale wrong");
  AST_BAD: assert property (div_code_bad |-> !reg_wr_en && $past(div_set_valid) && mult_of($past(div_set_code)) == 5'h00)
    else $error("refusal without an illegal code");
  // ----------------------------------------
  // classified pixel stream
  // ----------------------------------------
  AST_HOLD: assert property (cls_valid && !cls_ready |=> cls_valid && $stable(modulated_amplitude) && $stable(int_action))
    else $error("result changed while stalled");
  AST_FIRST_DEC: assert property (cls_valid && pix_class inside {CLS_SAT, CLS_BRIGHT, CLS_AMBIENT} |-> int_action == ACT_DEC)
    else $error("decrease missing");
  AST_NO_OBJ: assert property (cls_valid && pix_class == CLS_NO_OBJ |-> int_action == ACT_INC)
    else $error("increase missing");
  AST_AMP_CLS: assert property (cls_valid |-> amp_class == (modulated_amplitude < 12'h019 ? AMP_WEAK :
    modulated_amplitude < 12'h064 ? AMP_NOISY : modulated_amplitude <= 12'h7D0 ? AMP_GOOD : AMP_OVER))
    else $error("amplitude class wrong");
  AST_AMP_ACT: assert property (cls_valid && pix_class inside {CLS_USABLE, CLS_MARGINAL} |-> int_action ==
    (amp_class == AMP_OVER ? ACT_DEC : amp_class == AMP_GOOD ? ACT_KEEP : ACT_INC)) else $error("action wrong");
  AST_DIST: assert property (cls_valid |-> dist_valid == (pix_class == CLS_USABLE) && (!dist_valid || modulated_amplitude >= 12'h066))
    else $error("distance validity wrong");
  AST_AIM: assert property (cls_valid |-> amp_in_aim == (modulated_amplitude inside {[12'h0C8:12'h5DC]}))
    else $error("aim flag wrong");
endmodule

// ==== sim/tpqt_imager_model.sv ====
// imager register port: divider register with selectable write latency
`timescale 1ns/100ps
module tpqt_imager_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] lat,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output      logic       reg_wr_done,
  output      logic [7:0] mod_div_r,
  output      logic [4:0] int_mult
);
  logic [1:0] wait_r;
  // accept after lat pending cycles; slow settings test that the write is held
  assign reg_wr_done = reg_wr_en && (wait_r == lat);
  assign int_mult    = 5'(mod_div_r) + 5'h01;
  // divider register, code 1 after reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r    <= 2'h0;
      mod_div_r <= tpqt_pkg::MOD_CLK_DIV_RESET;
    end else begin
      wait_r <= (reg_wr_en && !reg_wr_done) ? wait_r + 2'h1 : 2'h0;
      if (reg_wr_done && reg_addr == tpqt_pkg::MOD_CLK_DIV_ADDR) mod_div_r <= reg_wdata;
    end
  end
endmodule

// ==== sim/tpqt_ctrl_test.sv ====
// bench for divider programming and pixel classification of tpqt_ctrl
`timescale 1ns/100ps
module tpqt_ctrl_test;
  import tpqt_pkg::*;
  typedef struct {logic [11:0] amp; logic [31:0] irr; logic [2:0] c; logic [1:0] a; logic [1:0] act;} tpqt_exp_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, div_set_valid = 1'b0, pix_valid = 1'b0, cls_ready = 1'b0, stall = 1'b0;
  logic pixel_overflow_flag = 1'b0, amr_enable = 1'b0;
  logic [7:0] div_set_code = 8'h00, ambient_to_modulated_ratio = 8'h00, mod_sensitivity = 8'h00;
  logic [15:0] t_int_ref = 16'h0000, t_int_used = 16'h0000;
  logic [1:0] lat = 2'h0;
  logic signed [11:0] s [4] = '{default: 12'h000};
  logic div_set_ack, reg_wr_en, reg_wr_done, div_code_bad, pix_ready, cls_valid, dist_valid, amp_in_aim;
  logic [7:0] reg_addr, reg_wdata, mod_div;
  logic [4:0] int_time_mult, model_mult;
  logic [11:0] unamb_dist_dm, dist_res_10um, modulated_amplitude;
  logic [31:0] modulated_irradiance;
  tpqt_cls_t pix_class;
  tpqt_amp_t amp_class;
  tpqt_act_t int_action;
  int fails = 0, num_checks = 0;
  tpqt_exp_t expq [$], e;
  int tbl [20][5] = '{'{100, 0, 900, 0, 1}, '{2040, 0, 0, 0, 0}, '{0, -2030, 0, 0, 0}, '{5, -10, 20, -20, 0},
    '{-2000, -2000, 2000, 2000, 0}, '{100, 100, 130, 100, 0}, '{0, 0, 48, 0, 0}, '{0, 0, 50, 0, 0},
    '{0, 0, 200, 0, 0}, '{0, 0, 204, 0, 0}, '{-2000, 0, 2000, 0, 0}, '{-2000, 0, 2004, 0, 0},
    '{-1000, 0, 2000, 0, 0}, '{-1000, 0, 2002, 0, 0}, '{0, 0, 40, 0, 0}, '{0, 0, 38, 0, 0},
    '{2027, 0, 0, 0, 0}, '{2028, 0, 0, 0, 0}, '{20, 0, -20, 0, 0}, '{21, 0, -21, 0, 0}};
  tpqt_ctrl dut (.sys_clk, .reset_n, .clk_en(1'b1), .div_set_valid, .div_set_code, .div_set_ack, .reg_wr_en,
    .reg_addr, .reg_wdata, .reg_wr_done, .int_time_mult, .unamb_dist_dm, .dist_res_10um, .div_code_bad,
    .pix_valid, .pix_ready, .phase_sample0(s[0]), .phase_sample1(s[1]), .phase_sample2(s[2]), .phase_sample3(s[3]),
    .pixel_overflow_flag, .amr_enable, .ambient_to_modulated_ratio, .mod_sensitivity, .t_int_ref, .t_int_used,
    .cls_valid, .cls_ready, .modulated_amplitude, .modulated_irradiance, .pix_class, .amp_class, .int_action,
    .dist_valid, .amp_in_aim);
  tpqt_imager_model imager (.sys_clk, .reset_n, .lat, .reg_wr_en, .reg_addr, .reg_wdata, .reg_wr_done,
    .mod_div_r(mod_div), .int_mult(model_mult));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always #20 sys_clk = ~sys_clk;
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reference classifier working on the pixel now offered
  function automatic tpqt_exp_t model();
    tpqt_exp_t r;
    int d0, d1, sq, rt, mx, a;
    d0 = int'(s[2]) - int'(s[0]);
    d1 = int'(s[3]) - int'(s[1]);
    sq = d0 * d0 + d1 * d1;
    rt = 0;
    mx = 0;
    while ((rt + 1) * (rt + 1) <= sq) rt++;
    for (int i = 0; i < 4; i++) begin
      a = (s[i] < 0) ? -int'(s[i]) : int'(s[i]);
      if (a > mx) mx = a;
    end
    r.amp = 12'(rt / 2);
    r.irr = (t_int_used == 0) ? 32'h0 : 32'(longint'(mod_sensitivity) * t_int_ref * r.amp / t_int_used);
    r.a = r.amp < AMP_WEAK_LIM ? AMP_WEAK : r.amp < AMP_NOISY_LIM ? AMP_NOISY : r.amp <= AMP_OVER_LIM ? AMP_GOOD : AMP_OVER;
    r.act = r.a == AMP_OVER ? ACT_DEC : r.a == AMP_GOOD ? ACT_KEEP : ACT_INC;
    if (pixel_overflow_flag) {r.c, r.act} = {CLS_SAT, ACT_DEC};
    else if (mx > FS_99_LSB || r.amp > FS_99_LSB) {r.c, r.act} = {CLS_BRIGHT, ACT_DEC};
    else if (mx <= FS_1_LSB || r.amp < FS_1_LSB) {r.c, r.act} = {CLS_NO_OBJ, ACT_INC};
    else if (amr_enable && ambient_to_modulated_ratio > AMR_WEAK_DB) {r.c, r.act} = {CLS_AMBIENT, ACT_DEC};
    else r.c = (r.amp >= FS_5_LSB && (!amr_enable || ambient_to_modulated_ratio < AMR_GOOD_DB)) ? CLS_USABLE : CLS_MARGINAL;
    return r;
  endfunction
  // offer one pixel, flag together with its samples, held until taken
  task automatic send(logic signed [11:0] a, logic signed [11:0] b, logic signed [11:0] c, logic signed [11:0] d, logic f);
    {s[0], s[1], s[2], s[3], pixel_overflow_flag} = {a, b, c, d, f};
    {amr_enable, ambient_to_modulated_ratio} = {1'($urandom), 8'($urandom % 90)};
    {mod_sensitivity, t_int_ref, t_int_used} = {8'($urandom), 16'($urandom), 16'($urandom % 500)};
    pix_valid = 1'b1;
    for (int n = 0; n < 200 && pix_ready !== 1'b1; n++) @(negedge sys_clk);
    check(pix_ready, 1'b1);
    expq.push_back(model());
    @(negedge sys_clk);
  endtask
  task automatic set_div(logic [7:0] code, logic [1:0] l, logic good);
    {lat, div_set_code, div_set_valid} = {l, code, 1'b1};
    for (int n = 0; n < 20 && div_set_ack !== 1'b1 && div_code_bad !== 1'b1; n++) @(negedge sys_clk);
    check(div_set_ack, good);
    check(div_code_bad, !good);
    div_set_valid = 1'b0;
    @(negedge sys_clk);
  endtask
  // pick ready for the coming edge, then score the result that edge takes
  always @(negedge sys_clk) begin
    cls_ready = stall ? 1'b0 : ($urandom % 4 != 0);
    if (cls_valid === 1'b1 && cls_ready === 1'b1) begin
      check(expq.size() != 0, 1'b1);
      e = expq.size() ? expq.pop_front() : '{12'h0, 32'h0, CLS_NONE, AMP_WEAK, ACT_KEEP};
      check(modulated_amplitude, e.amp);
      check(modulated_irradiance, e.irr);
      check(pix_class, e.c);
      check(amp_class, e.a);
      check(int_action, e.act);
      check(dist_valid, e.c == CLS_USABLE);
      check(amp_in_aim, e.amp >= AMP_AIM_LO && e.amp <= AMP_AIM_HI);
    end
  end
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    #800000;
    check(1'b0, 1'b1);
    tally_and_finish();
  end
  initial begin
    void'($urandom(89348));
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check(mod_div, 8'h01);
    check({int_time_mult, unamb_dist_dm, dist_res_10um}, {5'h02, 12'h096, 12'h1F4});
    for (int i = 0; i < 5; i++) begin
      set_div(8'((1 << i) - 1), 2'(i % 3), 1'b1);
      check(mod_div, (1 << i) - 1);
      check(int_time_mult, 1 << i);
      check(model_mult, 1 << i);
      check(unamb_dist_dm, 75 << i);
      check(dist_res_10um, 250 << i);
    end
    set_div(8'h02, 2'h0, 1'b0);
    set_div(8'h10, 2'h1, 1'b0);
    check({mod_div, 3'h0, int_time_mult}, 16'h0F10);
    foreach (tbl[i]) send(12'(tbl[i][0]), 12'(tbl[i][1]), 12'(tbl[i][2]), 12'(tbl[i][3]), 1'(tbl[i][4]));
    repeat (60) send(12'($urandom), 12'($urandom), 12'($urandom), 12'($urandom), $urandom % 8 == 0);
    stall = 1'b1;
    fork
      repeat (6) send(12'($urandom), 12'($urandom), 12'($urandom), 12'($urandom), 1'b0);
      begin
        repeat (12) @(negedge sys_clk);
        check(pix_ready, 1'b0);
        stall = 1'b0;
      end
    join
    pix_valid = 1'b0;
    for (int n = 0; n < 100 && expq.size() > 0; n++) @(negedge sys_clk);
    check(expq.size(), 0);
    tally_and_finish();
  end
endmodule
bind tpqt_ctrl tpqt_checker u_chk (.sys_clk, .reset_n, .div_set_valid, .div_set_code, .div_set_ack, .div_code_bad,
  .reg_wr_en, .reg_addr, .reg_wdata, .reg_wr_done, .int_time_mult, .unamb_dist_dm, .dist_res_10um, .cls_valid,
  .cls_ready, .modulated_amplitude, .pix_class, .amp_class, .int_action, .dist_valid, .amp_in_aim);
